// ===== mcu_exec_pkg.sv
// Constants for the instruction decode and execute block
// Operation
// - Fetch each instruction as one 15-bit word
// - Instruction cycle is 2 or 4 oscillator periods
// - Writing the program counter register takes two cycles
// - Jumps, calls, returns, true skips take two cycles
// - Timer clock is oscillator divided by 2 or 4
// - Any bit of any register tested; set or cleared in all but status
// - Port registers share the general register space
// - All-zero word does nothing, flags unchanged
// - Decimal adjust accumulator, updates carry only
// - Sleep clears watchdog, stops, updates time-out, power-down
// - Watchdog clear updates time-out and power-down flags
// - Interrupt enable and disable opcodes, no flags
// - Returns load counter from stack, one enables interrupts
// - Copy accumulator into register, flags unchanged
// - Clear accumulator or register, update zero flag
// - Register minus accumulator, update zero, carry, digit
// - Register minus one, update zero only
// - OR, AND, XOR with accumulator, zero only
// - Add accumulator and register, zero, carry, digit
// - Move register to accumulator or itself, zero
// - Complement register, update zero flag
// - Register plus one into accumulator, zero flag
// - Cycle-length option is configuration bit 11
package mcu_exec_pkg;
  localparam int INSTR_W = 15;
  localparam int PC_W = 12;
  localparam int REG_AW = 5;
  localparam int REG_COUNT = 32;
  localparam int STACK_D = 4;
  localparam int SP_W = 2;
  localparam int DIV_W = 2;
  // Oscillator periods per instruction cycle
  localparam int CYC_SHORT = 2;
  localparam int CYC_LONG = 4;
  // Control opcodes
  localparam logic [14:0] OP_IDLE = 15'h0000;
  localparam logic [14:0] OP_DEC_ADJUST = 15'h0001;
  localparam logic [14:0] OP_SLEEP = 15'h0003;
  localparam logic [14:0] OP_WDOG_CLEAR = 15'h0004;
  localparam logic [14:0] OP_INT_ON = 15'h0010;
  localparam logic [14:0] OP_INT_OFF = 15'h0011;
  localparam logic [14:0] OP_RET = 15'h0012;
  localparam logic [14:0] OP_RET_INT = 15'h0013;
  // Register-operand groups, instruction bits 14:8
  localparam logic [6:0] G_CTRL = 7'h00;
  localparam logic [6:0] G_MOVRA = 7'h01;
  localparam logic [6:0] G_CLR_ACC = 7'h02;
  localparam logic [6:0] G_CLR = 7'h03;
  localparam logic [6:0] G_SUBA = 7'h04;
  localparam logic [6:0] G_SUBR = 7'h05;
  localparam logic [6:0] G_DEC_ACC = 7'h06;
  localparam logic [6:0] G_DEC = 7'h07;
  localparam logic [6:0] G_ORA = 7'h08;
  localparam logic [6:0] G_ORR = 7'h09;
  localparam logic [6:0] G_ANDA = 7'h0a;
  localparam logic [6:0] G_ANDR = 7'h0b;
  localparam logic [6:0] G_XORA = 7'h0c;
  localparam logic [6:0] G_XORR = 7'h0d;
  localparam logic [6:0] G_ADDA = 7'h0e;
  localparam logic [6:0] G_ADDR = 7'h0f;
  localparam logic [6:0] G_MOVAR = 7'h10;
  localparam logic [6:0] G_MOVRR = 7'h11;
  localparam logic [6:0] G_COM_ACC = 7'h12;
  localparam logic [6:0] G_COM = 7'h13;
  localparam logic [6:0] G_INC_ACC = 7'h14;
  // Classes in instruction bits 14:12
  localparam logic [2:0] C_BITSET = 3'h2;
  localparam logic [2:0] C_BITTEST = 3'h3;
  localparam logic [2:0] C_CALL = 3'h4;
  localparam logic [2:0] C_JMP = 3'h5;
  // Special register designators
  localparam logic [7:0] RA_PC = 8'h02;
  localparam logic [7:0] RA_STATUS = 8'h03;
  localparam logic [7:0] RA_PORT = 8'h05;
  // Status field positions
  localparam int ST_Z = 0;
  localparam int ST_C = 1;
  localparam int ST_HALF = 2;
  localparam int ST_T = 3;
  localparam int ST_P = 4;
  localparam int ST_SLEEP = 5;
  localparam int ST_IE = 6;
  // Decimal adjust
  localparam logic [8:0] ADJ_LO = 9'h006;
  localparam logic [8:0] ADJ_HI = 9'h060;
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  // APB map
  localparam logic [7:0] A_CONFIG = 8'h00;
  localparam logic [7:0] A_CTRL = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h08;
  localparam logic [7:0] A_CORE = 8'h0c;
  localparam int CFG_CYCLE_BIT = 11;
  localparam int CTRL_RUN = 0;
  localparam int CORE_PC_LSB = 16;
  localparam logic [14:0] CFG_RESET = 15'h0000;
endpackage : mcu_exec_pkg

// ===== cycle_divider.sv
// Instruction cycle and timer clock divider
`timescale 1ns/1ns
module cycle_divider (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Cycle length select, high for four periods
  input wire logic four_period,
  // One pulse per instruction cycle
  output logic cycle_en
);
  import mcu_exec_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic en;
  } div_t;

  div_t s_reg;
  div_t s_next;
  logic [DIV_W-1:0] last;

  always_comb begin
    last = four_period ? DIV_W'(CYC_LONG - 1) : DIV_W'(CYC_SHORT - 1);
    s_next = s_reg;
    // Compare with >= so a switch to the short cycle never stalls
    s_next.en = (s_reg.cnt >= last);
    s_next.cnt = s_next.en ? '0 : s_reg.cnt + 1'b1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign cycle_en = s_reg.en;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_SHORT_CYCLE: assert property (
    (cycle_en && !four_period) ##1 !four_period |=> cycle_en)
    else $error("two-period cycle spacing wrong");
  AST_LONG_CYCLE: assert property (
    (cycle_en && four_period) ##1 four_period [*3] |=> cycle_en)
    else $error("four-period cycle spacing wrong");
  AST_LONG_GAP: assert property (
    (cycle_en && four_period) ##1 four_period [*2]
      |-> !cycle_en && !$past(cycle_en))
    else $error("four-period cycle pulse too early");
endmodule : cycle_divider

// ===== mcu_exec_core.sv
// Instruction decode and execute core with APB control
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ns
module mcu_exec_core (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic SRST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Program memory
  output logic [mcu_exec_pkg::PC_W-1:0] PROG_ADDR,
  input wire logic [mcu_exec_pkg::INSTR_W-1:0] PROG_DATA,
  // Port register pins
  input wire logic [7:0] PORT_IN,
  output logic [7:0] PORT_OUT,
  // Surrounding system
  input wire logic WAKE,
  output logic WDT_CLEAR,
  output logic TIMER_TICK,
  output logic INT_ENABLE,
  output logic SLEEPING
);
  import mcu_exec_pkg::*;

  typedef struct packed {
    logic [INSTR_W-1:0] ir;
    logic flush;
    logic [PC_W-1:0] pc;
    logic [7:0] acc;
    logic z;
    logic c;
    logic half_c;
    logic t;
    logic p;
    logic sleep;
    logic ie;
    logic [REG_COUNT-1:0][7:0] regs;
    logic [STACK_D-1:0][PC_W-1:0] stk;
    logic [SP_W-1:0] sp;
    logic [INSTR_W-1:0] cfg;
    logic run;
    logic wdt_clr;
    logic wake_s1;
    logic wake_s2;
    logic [7:0] io_s1;
    logic [7:0] io_s2;
    logic [7:0] port_out;
    logic [31:0] prdata;
    logic pslverr;
  } core_t;

  core_t s_reg;
  core_t s_next;
  logic cycle_en;
  logic step;
  logic exec;
  logic [6:0] grp;
  logic [7:0] rr;
  logic [7:0] src;
  logic [7:0] status8;

  cycle_divider u_div (
    .clk(CORE_CLK),
    .srst(SRST),
    .four_period(s_reg.cfg[CFG_CYCLE_BIT]),
    .cycle_en(cycle_en)
  );

  assign step = cycle_en && s_reg.run && !s_reg.sleep;
  assign exec = step && !s_reg.flush;
  assign grp = s_reg.ir[14:8];
  assign rr = s_reg.ir[7:0];

  always_comb begin
    status8 = '0;
    status8[ST_Z] = s_reg.z;
    status8[ST_C] = s_reg.c;
    status8[ST_HALF] = s_reg.half_c;
    status8[ST_T] = s_reg.t;
    status8[ST_P] = s_reg.p;
    status8[ST_SLEEP] = s_reg.sleep;
    status8[ST_IE] = s_reg.ie;
  end

  // Operand read; ports and counter live in the same space
  always_comb begin
    case (rr)
      RA_PC: src = s_reg.pc[7:0];
      RA_STATUS: src = status8;
      RA_PORT: src = s_reg.io_s2;
      default: src = s_reg.regs[rr[REG_AW-1:0]];
    endcase
  end

  always_comb begin
    logic [7:0] res;
    logic [8:0] sum;
    logic [4:0] nib;
    logic [8:0] adj;
    logic to_acc;
    logic to_reg;
    logic set_z;
    logic [SP_W-1:0] sp_dn;
    res = '0;
    sum = '0;
    nib = '0;
    adj = '0;
    to_acc = 1'b0;
    to_reg = 1'b0;
    set_z = 1'b0;
    sp_dn = s_reg.sp - 1'b1;
    s_next = s_reg;
    s_next.wdt_clr = 1'b0;
    s_next.wake_s1 = WAKE;
    s_next.wake_s2 = s_reg.wake_s1;
    s_next.io_s1 = PORT_IN;
    s_next.io_s2 = s_reg.io_s1;
    if (s_reg.sleep && s_reg.wake_s2) begin
      s_next.sleep = 1'b0;
    end
    if (step) begin
      s_next.ir = PROG_DATA;
      s_next.pc = s_reg.pc + 1'b1;
      s_next.flush = 1'b0;
    end
    // A flushed word falls through every branch untouched
    if (exec) begin
      // Groups up to 0x14 span classes 0 and 1
      if (grp <= G_INC_ACC) begin
        if (grp >= G_SUBA) begin
          to_acc = !grp[0];
          to_reg = grp[0];
          set_z = 1'b1;
        end
        case (grp)
          G_CTRL: begin
            case (s_reg.ir)
              OP_DEC_ADJUST: begin
                adj = {1'b0, s_reg.acc};
                if (adj[3:0] > DIGIT_MAX || s_reg.half_c) begin
                  adj = adj + ADJ_LO;
                end
                if (adj[7:4] > DIGIT_MAX || adj[8] || s_reg.c) begin
                  adj = adj + ADJ_HI;
                  s_next.c = 1'b1;
                end
                s_next.acc = adj[7:0];
              end
              OP_SLEEP: begin
                s_next.wdt_clr = 1'b1;
                s_next.t = 1'b1;
                s_next.p = 1'b0;
                s_next.sleep = 1'b1;
              end
              OP_WDOG_CLEAR: begin
                s_next.wdt_clr = 1'b1;
                s_next.t = 1'b1;
                s_next.p = 1'b1;
              end
              OP_INT_ON: s_next.ie = 1'b1;
              OP_INT_OFF: s_next.ie = 1'b0;
              OP_RET, OP_RET_INT: begin
                s_next.pc = s_reg.stk[sp_dn];
                s_next.sp = sp_dn;
                s_next.flush = 1'b1;
                if (s_reg.ir == OP_RET_INT) begin
                  s_next.ie = 1'b1;
                end
              end
              default: ;
            endcase
          end
          G_MOVRA: begin
            res = s_reg.acc;
            to_reg = 1'b1;
          end
          G_CLR_ACC: begin
            // Only the all-zero operand form is defined
            if (rr == 8'h00) begin
              to_acc = 1'b1;
              set_z = 1'b1;
            end
          end
          G_CLR: begin
            to_reg = 1'b1;
            set_z = 1'b1;
          end
          G_SUBA, G_SUBR: begin
            sum = {1'b0, src} - {1'b0, s_reg.acc};
            nib = {1'b0, src[3:0]} - {1'b0, s_reg.acc[3:0]};
            res = sum[7:0];
            s_next.c = !sum[8];
            s_next.half_c = !nib[4];
          end
          G_DEC_ACC, G_DEC: res = src - 1'b1;
          G_ORA, G_ORR: res = s_reg.acc | src;
          G_ANDA, G_ANDR: res = s_reg.acc & src;
          G_XORA, G_XORR: res = s_reg.acc ^ src;
          G_ADDA, G_ADDR: begin
            sum = {1'b0, src} + {1'b0, s_reg.acc};
            nib = {1'b0, src[3:0]} + {1'b0, s_reg.acc[3:0]};
            res = sum[7:0];
            s_next.c = sum[8];
            s_next.half_c = nib[4];
          end
          G_MOVAR, G_MOVRR: res = src;
          G_COM_ACC, G_COM: res = ~src;
          G_INC_ACC: res = src + 1'b1;
          default: ;
        endcase
      end else begin
        case (s_reg.ir[14:12])
          C_BITSET: begin
            res = src;
            res[s_reg.ir[10:8]] = s_reg.ir[11];
            to_reg = 1'b1;
          end
          C_BITTEST: begin
            // A true test discards the next word
            if (src[s_reg.ir[10:8]] == s_reg.ir[11]) begin
              s_next.flush = 1'b1;
            end
          end
          C_CALL, C_JMP: begin
            if (!s_reg.ir[12]) begin
              s_next.stk[s_reg.sp] = s_reg.pc;
              s_next.sp = s_reg.sp + 1'b1;
            end
            s_next.pc = s_reg.ir[PC_W-1:0];
            s_next.flush = 1'b1;
          end
          default: ;
        endcase
      end
      if (set_z) begin
        s_next.z = (res == 8'h00);
      end
      if (to_acc) begin
        s_next.acc = res;
      end
      if (to_reg) begin
        case (rr)
          RA_PC: begin
            s_next.pc = {s_reg.pc[PC_W-1:8], res};
            s_next.flush = 1'b1;
          end
          RA_STATUS: ;
          RA_PORT: s_next.port_out = res;
          default: s_next.regs[rr[REG_AW-1:0]] = res;
        endcase
      end
    end
    // APB read data is latched in the setup cycle
    if (PSEL && !PENABLE) begin
      s_next.prdata = '0;
      s_next.pslverr = 1'b0;
      case (PADDR)
        A_CONFIG: s_next.prdata[INSTR_W-1:0] = s_reg.cfg;
        A_CTRL: s_next.prdata[CTRL_RUN] = s_reg.run;
        A_STATUS: s_next.prdata[7:0] = status8;
        A_CORE: begin
          s_next.prdata[7:0] = s_reg.acc;
          s_next.prdata[CORE_PC_LSB +: PC_W] = s_reg.pc;
        end
        default: s_next.pslverr = 1'b1;
      endcase
    end
    if (PSEL && PENABLE && PWRITE) begin
      case (PADDR)
        A_CONFIG: s_next.cfg = PWDATA[INSTR_W-1:0];
        A_CTRL: s_next.run = PWDATA[CTRL_RUN];
        default: ;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      s_reg <= '0;
      s_reg.t <= 1'b1;
      s_reg.p <= 1'b1;
      s_reg.cfg <= CFG_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign PRDATA = s_reg.prdata;
  assign PREADY = 1'b1;
  assign PSLVERR = s_reg.pslverr;
  assign PROG_ADDR = s_reg.pc;
  assign PORT_OUT = s_reg.port_out;
  assign WDT_CLEAR = s_reg.wdt_clr;
  // Oscillator is stopped in sleep, so the timer clock halts too
  assign TIMER_TICK = cycle_en && !s_reg.sleep;
  assign INT_ENABLE = s_reg.ie;
  assign SLEEPING = s_reg.sleep;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);

  AST_NOP_KEEPS_FLAGS: assert property (
    exec && s_reg.ir == OP_IDLE |=> $stable(status8) && $stable(s_reg.acc))
    else $error("no-op changed state");
  AST_ADJUST_CARRY_ONLY: assert property (
    exec && s_reg.ir == OP_DEC_ADJUST
      |=> $stable(s_reg.z) && $stable(s_reg.half_c))
    else $error("decimal adjust touched other flags");
  AST_SLEEP_ENTRY: assert property (
    exec && s_reg.ir == OP_SLEEP |=> SLEEPING && WDT_CLEAR && s_reg.t
      && !s_reg.p ##1 !WDT_CLEAR)
    else $error("sleep entry wrong");
  AST_WDOG_FLAGS: assert property (
    exec && s_reg.ir == OP_WDOG_CLEAR |=> WDT_CLEAR && s_reg.t && s_reg.p
      && !SLEEPING)
    else $error("watchdog clear wrong");
  AST_INT_ENABLE: assert property (
    exec && s_reg.ir == OP_INT_ON |=> INT_ENABLE && $stable(s_reg.z))
    else $error("interrupt enable opcode failed");
  AST_PC_WRITE_TWO: assert property (
    exec && grp == G_MOVRA && rr == RA_PC
      |=> s_reg.flush && PROG_ADDR[7:0] == $past(s_reg.acc))
    else $error("counter write not two cycles");
  AST_FLUSH_IS_NOP: assert property (
    step && s_reg.flush |=> $stable(s_reg.acc) && $stable(status8)
      && !s_reg.flush)
    else $error("discarded word had an effect");
  AST_CLEAR_ACC: assert property (
    exec && s_reg.ir == 15'h0200 |=> s_reg.acc == 8'h00 && s_reg.z)
    else $error("clear accumulator wrong");
  AST_ADD_ACC: assert property (
    exec && grp == G_ADDA
      |=> s_reg.acc == 8'($past(s_reg.acc) + $past(src))
      && s_reg.z == (s_reg.acc == 8'h00))
    else $error("add result wrong");
  AST_MOV_ACC: assert property (
    exec && grp == G_MOVRA && rr == RA_PORT
      |=> PORT_OUT == $past(s_reg.acc) && $stable(status8))
    else $error("accumulator copy wrong");
endmodule : mcu_exec_core

// ===== mcu_exec_core_tb_top.sv
// Self-checking bench for the instruction decode and execute core
`timescale 1ns/1ns
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
  fail_count++; $display("[FAIL] t=%0t got %0h exp %0h", $time, a, e); \
  end end
module mcu_exec_core_tb_top;
  import mcu_exec_pkg::*;
  typedef logic [14:0] prog_t [16];
  typedef struct packed {
    logic [14:0] w;
    logic [7:0] acc;
    logic [7:0] port;
    logic [7:0] st;
  } vec_t;
  // Core starts with acc=c3, operand register 0x05 reads 3c
  vec_t vecs [27] = '{
    '{15'h0000, 8'hc3, 8'h00, 8'h18}, '{15'h0002, 8'hc3, 8'h00, 8'h18},
    '{15'h0001, 8'h23, 8'h00, 8'h1a}, '{15'h0010, 8'hc3, 8'h00, 8'h58},
    '{15'h0011, 8'hc3, 8'h00, 8'h18}, '{15'h0105, 8'hc3, 8'hc3, 8'h18},
    '{15'h0200, 8'h00, 8'h00, 8'h19}, '{15'h0305, 8'hc3, 8'h00, 8'h19},
    '{15'h0405, 8'h79, 8'h00, 8'h1c}, '{15'h0505, 8'hc3, 8'h79, 8'h1c},
    '{15'h0605, 8'h3b, 8'h00, 8'h18}, '{15'h0705, 8'hc3, 8'h3b, 8'h18},
    '{15'h0805, 8'hff, 8'h00, 8'h18}, '{15'h0905, 8'hc3, 8'hff, 8'h18},
    '{15'h0a05, 8'h00, 8'h00, 8'h19}, '{15'h0b05, 8'hc3, 8'h00, 8'h19},
    '{15'h0c05, 8'hff, 8'h00, 8'h18}, '{15'h0d05, 8'hc3, 8'hff, 8'h18},
    '{15'h0e05, 8'hff, 8'h00, 8'h18}, '{15'h0f05, 8'hc3, 8'hff, 8'h18},
    '{15'h1005, 8'h3c, 8'h00, 8'h18}, '{15'h1105, 8'hc3, 8'h3c, 8'h18},
    '{15'h1205, 8'hc3, 8'h00, 8'h18}, '{15'h1305, 8'hc3, 8'hc3, 8'h18},
    '{15'h1405, 8'h3d, 8'h00, 8'h18}, '{15'h2f05, 8'hc3, 8'hbc, 8'h18},
    '{15'h2205, 8'hc3, 8'h38, 8'h18}};
  logic core_clk, srst, psel, penable, pwrite, pready, pslverr, wake;
  logic [7:0] paddr, port_in, port_out;
  logic [31:0] pwdata, prdata;
  logic [PC_W-1:0] prog_addr;
  logic [INSTR_W-1:0] prog_data;
  logic wdt_clear, timer_tick, int_enable, sleeping;
  logic [14:0] rom [16];
  int fail_count = 0;
  int check_count = 0;
  int wdt_n = 0;

  // Asynchronous program store, answers in the same clock
  assign prog_data = rom[prog_addr[3:0]];

  mcu_exec_core uut (
    .CORE_CLK(core_clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .PROG_ADDR(prog_addr),
    .PROG_DATA(prog_data), .PORT_IN(port_in), .PORT_OUT(port_out),
    .WAKE(wake), .WDT_CLEAR(wdt_clear), .TIMER_TICK(timer_tick),
    .INT_ENABLE(int_enable), .SLEEPING(sleeping)
  );

  always @(negedge core_clk) begin
    if (wdt_clear === 1'b1) wdt_n++;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic hang;
    fail_count++;
    final_report();
  endtask : hang

  // One APB transfer, then an idle cycle
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) hang();
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask : rd

  task automatic load(input prog_t p);
    foreach (rom[i]) rom[i] <= p[i];
  endtask : load

  // Fresh reset, pick cycle length, start execution
  task automatic run_prog(input logic four, input int clocks);
    logic [31:0] q;
    logic e;
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    apb(1'b1, A_CONFIG, 32'(four) << CFG_CYCLE_BIT, q, e);
    apb(1'b1, A_CTRL, 32'h1, q, e);
    repeat (clocks) @(posedge core_clk);
  endtask : run_prog

  task automatic t_reset;
    logic [31:0] q;
    logic e;
    rd(A_STATUS, q);
    `CHK(q[6:0], 7'h18)
    rd(A_CONFIG, q);
    `CHK(q[14:0], CFG_RESET)
    apb(1'b1, 8'h40, 32'h1, q, e);
    `CHK(e, 1'b1)
  endtask : t_reset

  task automatic t_ticks(input logic four);
    int n;
    n = 0;
    run_prog(four, 8);
    repeat (40) begin
      @(negedge core_clk);
      if (timer_tick === 1'b1) n++;
    end
    `CHK(n, four ? 10 : 20)
    @(posedge core_clk);
  endtask : t_ticks

  task automatic t_table;
    prog_t p;
    logic [31:0] q;
    p = '{default: 15'h0};
    p[0] = 15'h1005;
    p[1] = 15'h1205;
    p[3] = 15'h5003;
    port_in <= 8'h3c;
    foreach (vecs[i]) begin
      p[2] = vecs[i].w;
      load(p);
      run_prog(1'b0, 30);
      rd(A_CORE, q);
      `CHK(q[7:0], vecs[i].acc)
      rd(A_STATUS, q);
      `CHK(q[6:0], vecs[i].st[6:0])
      `CHK(port_out, vecs[i].port)
    end
  endtask : t_table

  // Any word wrongly run after the counter write, call or return adds 6 to acc
  task automatic t_jump(input logic four);
    prog_t p;
    logic [31:0] q;
    p = '{default: 15'h0e05};
    p[0] = 15'h1005;
    p[1] = 15'h0102;
    p[6] = 15'h4009;
    p[8] = 15'h5008;
    p[9] = 15'h0013;
    port_in <= 8'h06;
    load(p);
    run_prog(four, 150);
    rd(A_CORE, q);
    `CHK(q[7:0], 8'h0c)
    rd(A_STATUS, q);
    `CHK(q[6:0], 7'h58)
    `CHK(int_enable, 1'b1)
  endtask : t_jump

  task automatic t_sleep;
    prog_t p;
    logic [31:0] q;
    int n;
    p = '{default: 15'h0};
    p[0] = 15'h0004;
    p[1] = 15'h0003;
    p[3] = 15'h1005;
    p[4] = 15'h5004;
    port_in <= 8'h5a;
    load(p);
    wdt_n = 0;
    run_prog(1'b0, 20);
    `CHK(sleeping, 1'b1)
    `CHK(wdt_n, 2)
    n = 0;
    repeat (20) begin
      @(negedge core_clk);
      if (timer_tick === 1'b1) n++;
    end
    `CHK(n, 0)
    @(posedge core_clk);
    wake <= 1'b1;
    n = 0;
    while (sleeping !== 1'b0 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 20) hang();
    wake <= 1'b0;
    repeat (30) @(posedge core_clk);
    rd(A_CORE, q);
    `CHK(q[7:0], 8'h5a)
  endtask : t_sleep

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    port_in = 8'h3c;
    wake = 1'b0;
    foreach (rom[i]) rom[i] = 15'h0;
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_ticks(1'b0);
    t_ticks(1'b1);
    t_table();
    t_jump(1'b0);
    t_jump(1'b1);
    t_sleep();
    final_report();
  end
endmodule : mcu_exec_core_tb_top
